// *** core/rtcam_pkg.sv ***
// Shared constants, types and register map of the alarm and clock-out block.
// Overview of operation
// - Match-select picks seconds, minutes, hours, weekday or date; code 110 never matches.
// - Code 101 matches hundredths on alarm 1 only; alarm 0 treats it reserved.
// - Code 111 matches seconds, minutes, hours, weekday and date, not hundredths; alarm 0 also requires the month to match.
// - Hours compare honours 12/24-hour format and the afternoon indicator.
// - A selected match on an enabled alarm sets the sticky hit flag at weekday register bit 3.
// - Writing zero clears the hit flag; writing one leaves it unchanged.
// - Weekday value sits in bits 2-0, resets to 1, software loads 1 to 7.
// - Date match is BCD in bits 5-0, bits 7-6 read zero, resets to 0x01.
// - Month match at 0x11 is BCD in bits 4-0, bits 7-5 read zero.
// - Bit 7 of each weekday register is reserved and reads zero.
// - Clock-out enable bit 6 puts the square wave on the pin, else alarms.
// - On backup supply alarms still drive the pin; square wave is disabled.
// - Square-wave settings are kept through backup and resume on main power.
// - Rate select codes 00 to 11 give 1 Hz, 4.096, 8.192, 32.768 kHz.
// - Postscaler divides the oscillator by 32768, 8, 4 or 1.
// - Trimming affects every divided rate but not the 1:1 pass-through.
// - Rate select is ignored when clock out is off or coarse trim is on.
// - Coarse trim bit 2 trims each second and gives a trimmed 1 Hz output.
// - Control bit 5 enables alarm 1 and bit 4 enables alarm 0.
// - Control bit 3 enables an external 32.768 kHz source on the crystal pin.
// - Either enabled alarm pulls the pin low until both flags are cleared.
package rtcam_pkg;

    // ==========================================================
    // Register offsets
    localparam logic [7:0] ADDR_CONTROL = 8'h08;
    localparam logic [7:0] ADDR_A0_SEC = 8'h0c;
    localparam logic [7:0] ADDR_A0_MIN = 8'h0d;
    localparam logic [7:0] ADDR_A0_HOUR = 8'h0e;
    localparam logic [7:0] ADDR_A0_WEEKDAY_VALUE = 8'h0f;
    localparam logic [7:0] ADDR_A0_DATE = 8'h10;
    localparam logic [7:0] ADDR_A0_MONTH = 8'h11;
    localparam logic [7:0] ADDR_A1_HSEC = 8'h12;
    localparam logic [7:0] ADDR_A1_SEC = 8'h13;
    localparam logic [7:0] ADDR_A1_MIN = 8'h14;
    localparam logic [7:0] ADDR_A1_HOUR = 8'h15;
    localparam logic [7:0] ADDR_A1_WEEKDAY_VALUE = 8'h16;
    localparam logic [7:0] ADDR_A1_DATE = 8'h17;

    // ==========================================================
    // Field positions and masks
    localparam int CTL_CLK_OUT_EN = 6;
    localparam int CTL_ALM1_EN = 5;
    localparam int CTL_ALM0_EN = 4;
    localparam int CTL_EXT_OSC = 3;
    localparam int CTL_COARSE_TRIM = 2;
    localparam int WKD_HIT_FLAG = 3;
    localparam int HOUR_FMT_12 = 6;
    localparam logic [7:0] CTL_WMASK = 8'h7f;
    localparam logic [7:0] CTL_RSVD_READ = 8'h80;
    localparam logic [7:0] SEC_MASK = 8'h7f;
    localparam logic [7:0] HOUR_MASK = 8'h3f;
    localparam logic [7:0] DATE_MASK = 8'h3f;
    localparam logic [7:0] MONTH_MASK = 8'h1f;

    // ==========================================================
    // Values after reset
    localparam logic [6:0] CTL_RESET = 7'h00;
    localparam logic [2:0] WEEKDAY_VALUE_RESET = 3'h1;
    localparam logic [5:0] DATE_RESET = 6'h01;
    localparam logic [4:0] MONTH_RESET = 5'h01;

    // ==========================================================
    // Clock-out rate codes and postscaler ratios
    localparam logic [1:0] RATE_1HZ = 2'h0;
    localparam logic [1:0] RATE_4K = 2'h1;
    localparam logic [1:0] RATE_8K = 2'h2;
    localparam logic [1:0] RATE_32K = 2'h3;
    localparam int DIV_1HZ = 32768;
    localparam int DIV_4K = 8;
    localparam int DIV_8K = 4;
    localparam logic [14:0] HALF_1HZ = 15'(DIV_1HZ / 2 - 1);
    localparam logic [14:0] HALF_4K = 15'(DIV_4K / 2 - 1);
    localparam logic [14:0] HALF_8K = 15'(DIV_8K / 2 - 1);

    // ==========================================================
    // Types
    typedef enum logic [2:0] {
        MSEL_SEC = 3'h0,
        MSEL_MIN = 3'h1,
        MSEL_HOUR = 3'h2,
        MSEL_WEEKDAY_VALUE = 3'h3,
        MSEL_DATE = 3'h4,
        MSEL_HSEC = 3'h5,
        MSEL_RSVD = 3'h6,
        MSEL_ALL = 3'h7
    } rtcam_msel_e;

    typedef struct packed {
        logic [7:0] hsec;
        logic [6:0] sec;
        logic [6:0] min;
        logic [6:0] hour;
        logic [2:0] weekday_value;
        logic [5:0] date;
        logic [4:0] month;
    } rtcam_time_s;

    typedef struct packed {
        rtcam_msel_e msel;
        logic [7:0] hsec;
        logic [6:0] sec;
        logic [6:0] min;
        logic [5:0] hour;
        logic [2:0] weekday_value;
        logic [5:0] date;
        logic [4:0] month;
    } rtcam_alarm_s;

endpackage

// *** core/rtcam_match.sv ***
// Field comparator of one alarm unit.
`timescale 1ns/10ps
module rtcam_match #(
    parameter bit HAS_HSEC = 1'b0,
    parameter bit HAS_MONTH = 1'b0
) (
    input wire rtcam_pkg::rtcam_time_s now_i,
    input wire rtcam_pkg::rtcam_alarm_s cfg_i,
    output logic match_o
);
    import rtcam_pkg::*;

    logic eq_sec;
    logic eq_min;
    logic eq_hour;
    logic eq_wkd;
    logic eq_date;
    logic eq_mon;

    assign eq_sec = now_i.sec == cfg_i.sec;
    assign eq_min = now_i.min == cfg_i.min;
    // format-aware hours
    // Bits 5-0 hold the tens digit and, in 12-hour mode, the afternoon bit.
    assign eq_hour = now_i.hour[5:0] == cfg_i.hour;
    assign eq_wkd = now_i.weekday_value == cfg_i.weekday_value;
    assign eq_date = now_i.date == cfg_i.date;
    assign eq_mon = !HAS_MONTH || (now_i.month == cfg_i.month);

    always_comb begin
        unique case (cfg_i.msel)
            MSEL_SEC: match_o = eq_sec;
            MSEL_MIN: match_o = eq_min;
            MSEL_HOUR: match_o = eq_hour;
            MSEL_WEEKDAY_VALUE: match_o = eq_wkd;
            MSEL_DATE: match_o = eq_date;
            MSEL_HSEC: match_o = HAS_HSEC && (now_i.hsec == cfg_i.hsec);
            MSEL_RSVD: match_o = 1'b0;
            MSEL_ALL: match_o = eq_sec && eq_min && eq_hour && eq_wkd
                && eq_date && eq_mon;
        endcase
    end

endmodule

// *** core/rtcam_top.sv ***
// Alarm match units, their registers and the multi-function pin driver.
`timescale 1ns/10ps
module rtcam_top (
    input wire logic ref_clk_i,
    input wire logic rst_b_i,
    input wire logic reg_wr_i,
    input wire logic [7:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    output logic [7:0] reg_rdata_o,
    input wire rtcam_pkg::rtcam_time_s now_i,
    input wire logic osc_tick_i,
    input wire logic osc_level_i,
    input wire logic trim_add_i,
    input wire logic trim_drop_i,
    input wire logic backup_i,
    output logic multi_function_pin_o,
    output logic multi_function_pin_oe_o,
    output logic external_osc_input_o,
    output logic coarse_trim_enable_o
);
    import rtcam_pkg::*;

    // ==========================================================
    // Reset release
    logic rst_meta;
    logic rst_b;

    always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            rst_meta <= 1'b0;
            rst_b <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_b <= rst_meta;
        end
    end

    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (!rst_b);

    // ==========================================================
    // Control register
    logic [6:0] control;
    logic clock_out_enable;
    logic coarse_trim_enable;
    logic [1:0] clock_out_rate_select;
    logic [1:0] alarm_enable;

    // settings kept through backup
    // The register is never touched by the supply state, so the square
    // wave returns by itself when main power comes back.
    always_ff @(posedge ref_clk_i or negedge rst_b) begin
        if (!rst_b) begin
            control <= CTL_RESET;
        end else if (reg_wr_i && reg_addr_i == ADDR_CONTROL) begin
            control <= reg_wdata_i[6:0] & CTL_WMASK[6:0];
        end
    end

    assign clock_out_enable = control[CTL_CLK_OUT_EN];
    assign coarse_trim_enable = control[CTL_COARSE_TRIM];
    assign clock_out_rate_select = control[1:0];
    assign alarm_enable[0] = control[CTL_ALM0_EN];
    assign alarm_enable[1] = control[CTL_ALM1_EN];

    always_ff @(posedge ref_clk_i or negedge rst_b) begin
        if (!rst_b) begin
            external_osc_input_o <= 1'b0;
            coarse_trim_enable_o <= 1'b0;
        end else begin
            external_osc_input_o <= control[CTL_EXT_OSC];
            coarse_trim_enable_o <= coarse_trim_enable;
        end
    end

    // ==========================================================
    // Alarm units
    rtcam_alarm_s alarm_cfg [2];
    logic [1:0] alarm_hit_flag;
    logic [1:0] alarm_match;
    logic [1:0] alarm_match_q;
    logic [1:0] alarm_set;
    logic [1:0] flag_clear;
    logic [7:0] addr_sec [2];
    logic [7:0] addr_min [2];
    logic [7:0] addr_hour [2];
    logic [7:0] addr_wkd [2];
    logic [7:0] addr_date [2];

    assign addr_sec[0] = ADDR_A0_SEC;
    assign addr_sec[1] = ADDR_A1_SEC;
    assign addr_min[0] = ADDR_A0_MIN;
    assign addr_min[1] = ADDR_A1_MIN;
    assign addr_hour[0] = ADDR_A0_HOUR;
    assign addr_hour[1] = ADDR_A1_HOUR;
    assign addr_wkd[0] = ADDR_A0_WEEKDAY_VALUE;
    assign addr_wkd[1] = ADDR_A1_WEEKDAY_VALUE;
    assign addr_date[0] = ADDR_A0_DATE;
    assign addr_date[1] = ADDR_A1_DATE;

    genvar g;
    generate
        for (g = 0; g < 2; g++) begin : g_alarm
            logic wr_wkd;

            assign wr_wkd = reg_wr_i && reg_addr_i == addr_wkd[g];

            always_ff @(posedge ref_clk_i or negedge rst_b) begin
                if (!rst_b) begin
                    alarm_cfg[g].msel <= MSEL_SEC;
                    alarm_cfg[g].sec <= 7'h00;
                    alarm_cfg[g].min <= 7'h00;
                    alarm_cfg[g].hour <= 6'h00;
                    alarm_cfg[g].weekday_value <= WEEKDAY_VALUE_RESET;
                    alarm_cfg[g].date <= DATE_RESET;
                end else if (reg_wr_i) begin
                    if (reg_addr_i == addr_sec[g]) begin
                        alarm_cfg[g].sec <= reg_wdata_i[6:0];
                    end
                    if (reg_addr_i == addr_min[g]) begin
                        alarm_cfg[g].min <= reg_wdata_i[6:0];
                    end
                    if (reg_addr_i == addr_hour[g]) begin
                        alarm_cfg[g].hour <= reg_wdata_i[5:0];
                    end
                    if (wr_wkd) begin
                        alarm_cfg[g].msel <= rtcam_msel_e'(reg_wdata_i[6:4]);
                        alarm_cfg[g].weekday_value <= reg_wdata_i[2:0];
                    end
                    if (reg_addr_i == addr_date[g]) begin
                        alarm_cfg[g].date <= reg_wdata_i[5:0];
                    end
                end
            end

            assign flag_clear[g] = wr_wkd && !reg_wdata_i[WKD_HIT_FLAG];
            assign alarm_set[g] = alarm_enable[g] && alarm_match[g]
                && !alarm_match_q[g];

            always_ff @(posedge ref_clk_i or negedge rst_b) begin
                if (!rst_b) begin
                    alarm_hit_flag[g] <= 1'b0;
                    alarm_match_q[g] <= 1'b0;
                end else begin
                    alarm_match_q[g] <= alarm_match[g];
                    if (alarm_set[g]) begin
                        alarm_hit_flag[g] <= 1'b1;
                    end else if (flag_clear[g]) begin
                        alarm_hit_flag[g] <= 1'b0;
                    end
                end
            end

            rtcam_match #(
                .HAS_HSEC(g == 1),
                .HAS_MONTH(g == 0)
            ) u_match (
                .now_i(now_i),
                .cfg_i(alarm_cfg[g]),
                .match_o(alarm_match[g])
            );

            flag_rise_a: assert property (
                alarm_set[g] |=> alarm_hit_flag[g]
                    ##1 (alarm_hit_flag[g] || $past(flag_clear[g]))
            ) else $error("alarm flag did not set and hold");
            flag_clear_a: assert property (
                flag_clear[g] && !alarm_set[g] |=> !alarm_hit_flag[g]
            ) else $error("flag not cleared by zero write");
            flag_keep_a: assert property (
                alarm_hit_flag[g] && !flag_clear[g] |=> alarm_hit_flag[g]
            ) else $error("flag dropped without a clear");
            flag_enable_a: assert property (
                $rose(alarm_hit_flag[g]) |-> $past(alarm_enable[g])
                    && $past(alarm_match[g]) && !$past(alarm_match_q[g])
            ) else $error("flag rose without a fresh enabled match");
            rsvd_code_a: assert property (
                alarm_cfg[g].msel == MSEL_RSVD |-> !alarm_match[g]
            ) else $error("reserved select produced a match");
        end
    endgenerate

    // Hundredths on alarm 1 and month on alarm 0 only.
    logic [7:0] a1_hsec;
    logic [4:0] a0_month;

    always_ff @(posedge ref_clk_i or negedge rst_b) begin
        if (!rst_b) begin
            a1_hsec <= 8'h00;
            a0_month <= MONTH_RESET;
        end else if (reg_wr_i) begin
            if (reg_addr_i == ADDR_A1_HSEC) begin
                a1_hsec <= reg_wdata_i;
            end
            if (reg_addr_i == ADDR_A0_MONTH) begin
                a0_month <= reg_wdata_i[4:0];
            end
        end
    end

    // The unused copies stay constant and are ignored by the comparator.
    always_comb begin
        alarm_cfg[0].hsec = 8'h00;
        alarm_cfg[0].month = a0_month;
        alarm_cfg[1].hsec = a1_hsec;
        alarm_cfg[1].month = 5'h00;
    end

    // ==========================================================
    // Register read-back
    logic [7:0] next_rdata;

    always_comb begin
        next_rdata = 8'h00;
        unique case (reg_addr_i)
            ADDR_CONTROL: next_rdata = CTL_RSVD_READ | {1'b0, control};
            ADDR_A0_SEC: next_rdata = {1'b0, alarm_cfg[0].sec};
            ADDR_A0_MIN: next_rdata = {1'b0, alarm_cfg[0].min};
            ADDR_A0_HOUR: next_rdata = {1'b0, now_i.hour[HOUR_FMT_12],
                alarm_cfg[0].hour};
            ADDR_A0_WEEKDAY_VALUE: next_rdata = {1'b0, alarm_cfg[0].msel,
                alarm_hit_flag[0], alarm_cfg[0].weekday_value};
            ADDR_A0_DATE: next_rdata = {2'h0, alarm_cfg[0].date};
            ADDR_A0_MONTH: next_rdata = {3'h0, a0_month};
            ADDR_A1_HSEC: next_rdata = a1_hsec;
            ADDR_A1_SEC: next_rdata = {1'b0, alarm_cfg[1].sec};
            ADDR_A1_MIN: next_rdata = {1'b0, alarm_cfg[1].min};
            ADDR_A1_HOUR: next_rdata = {1'b0, now_i.hour[HOUR_FMT_12],
                alarm_cfg[1].hour};
            ADDR_A1_WEEKDAY_VALUE: next_rdata = {1'b0, alarm_cfg[1].msel,
                alarm_hit_flag[1], alarm_cfg[1].weekday_value};
            ADDR_A1_DATE: next_rdata = {2'h0, alarm_cfg[1].date};
            default: next_rdata = 8'h00;
        endcase
    end

    always_ff @(posedge ref_clk_i or negedge rst_b) begin
        if (!rst_b) begin
            reg_rdata_o <= 8'h00;
        end else begin
            reg_rdata_o <= next_rdata;
        end
    end

    // ==========================================================
    // Square-wave postscaler
    logic trimmed_tick;
    logic [14:0] half_count;
    logic [14:0] half_limit;
    logic divided_wave;
    logic square_wave;
    logic pass_through;

    // trim acts on divided rates only
    assign trimmed_tick = (osc_tick_i && !trim_drop_i) || trim_add_i;

    always_comb begin
        half_limit = HALF_1HZ;
        if (!coarse_trim_enable) begin
            unique case (clock_out_rate_select)
                RATE_1HZ: half_limit = HALF_1HZ;
                RATE_4K: half_limit = HALF_4K;
                RATE_8K: half_limit = HALF_8K;
                RATE_32K: half_limit = HALF_1HZ;
            endcase
        end
    end

    assign pass_through = !coarse_trim_enable
        && clock_out_rate_select == RATE_32K;

    always_ff @(posedge ref_clk_i or negedge rst_b) begin
        if (!rst_b) begin
            half_count <= 15'h0000;
            divided_wave <= 1'b0;
        end else if (!clock_out_enable) begin
            half_count <= 15'h0000;
            divided_wave <= 1'b0;
        end else if (trimmed_tick) begin
            if (half_count >= half_limit) begin
                half_count <= 15'h0000;
                divided_wave <= !divided_wave;
            end else begin
                half_count <= half_count + 15'h0001;
            end
        end
    end

    assign square_wave = pass_through ? osc_level_i : divided_wave;

    // ==========================================================
    // Multi-function pin
    logic sqw_mode;
    logic any_flag;

    // clock out selects the pin source
    assign sqw_mode = clock_out_enable && !backup_i;
    assign any_flag = |alarm_hit_flag;

    always_ff @(posedge ref_clk_i or negedge rst_b) begin
        if (!rst_b) begin
            multi_function_pin_o <= 1'b1;
            multi_function_pin_oe_o <= 1'b0;
        end else if (sqw_mode) begin
            multi_function_pin_o <= square_wave;
            multi_function_pin_oe_o <= 1'b1;
        end else begin
            multi_function_pin_o <= !any_flag;
            multi_function_pin_oe_o <= any_flag;
        end
    end

    // ==========================================================
    // Checks
    pin_alarm_a: assert property (
        !sqw_mode && any_flag |=> multi_function_pin_oe_o
            && !multi_function_pin_o
    ) else $error("pin not pulled low for a set flag");
    pin_release_a: assert property (
        !sqw_mode && !any_flag |=> !multi_function_pin_oe_o
    ) else $error("pin not released while idle");
    backup_pin_a: assert property (
        backup_i |=> multi_function_pin_oe_o == $past(any_flag)
    ) else $error("square wave seen on backup supply");
    month_read_a: assert property (
        reg_addr_i == ADDR_A0_MONTH |=> reg_rdata_o[7:5] == 3'h0
            && reg_rdata_o[4:0] == $past(a0_month)
    ) else $error("month read-back wrong");
    div_bound_a: assert property (
        clock_out_enable |-> half_count <= HALF_1HZ
    ) else $error("postscaler count out of range");
    coarse_rate_a: assert property (
        coarse_trim_enable |-> half_limit == HALF_1HZ && !pass_through
    ) else $error("coarse trim did not force 1 Hz");

endmodule

// *** sim/rtcam_host.sv ***
// Host model that reaches the alarm block registers.
`timescale 1ns/10ps
module rtcam_host (
    input wire logic clk_i,
    input wire logic [7:0] rdata_i,
    output logic wr_o,
    output logic [7:0] addr_o,
    output logic [7:0] wdata_o
);
    initial begin
        wr_o = 1'b0;
        addr_o = 8'h00;
        wdata_o = 8'h00;
    end
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk_i);
        wr_o = 1'b1;
        addr_o = a;
        wdata_o = d;
        @(negedge clk_i);
        wr_o = 1'b0;
        wdata_o = ~d;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(negedge clk_i);
        addr_o = a;
        @(negedge clk_i);
        @(negedge clk_i);
        d = rdata_i;
    endtask
    // Clear the flag, load the match, then enable.
    task automatic arm(input logic [7:0] w, r, v, ctl, input logic [2:0] m);
        wr(w, {1'b0, m, 4'h3});
        wr(r, v);
        wr(8'h08, ctl);
    endtask
endmodule

// *** sim/tb_top.sv ***
// Self-checking bench of the alarm and clock-out block.
`timescale 1ns/10ps
module tb_top;
    import rtcam_pkg::*;
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic tick = 1'b0;
    logic drop = 1'b0;
    logic bkp = 1'b0;
    logic wr, pin, oe, ext, crs;
    logic [7:0] addr, wdata, rdata, d;
    rtcam_time_s now = '0;
    int error_cnt = 0;
    int checks = 0;
    always #5 clk = ~clk;
    always @(negedge clk) tick <= ~tick;
    rtcam_top u_rtcam_top (.ref_clk_i(clk), .rst_b_i(rst_b), .reg_wr_i(wr),
        .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_rdata_o(rdata),
        .now_i(now), .osc_tick_i(tick), .osc_level_i(tick),
        .trim_add_i(1'b0), .trim_drop_i(drop & tick), .backup_i(bkp),
        .multi_function_pin_o(pin), .multi_function_pin_oe_o(oe),
        .external_osc_input_o(ext), .coarse_trim_enable_o(crs));
    rtcam_host u_rtcam_host (.clk_i(clk), .rdata_i(rdata), .wr_o(wr),
        .addr_o(addr), .wdata_o(wdata));
    // ==========================================================
    // Shared checks
    task automatic chk(input logic [7:0] g, e, input string m);
        checks++;
        if (g !== e) begin
            error_cnt++;
            $display("FAIL %0t %s got %h", $time, m, g);
        end
    endtask
    task automatic rchk(input logic [7:0] a, e);
        u_rtcam_host.rd(a, d);
        chk(d, e, $sformatf("read %h", a));
    endtask
    task automatic close_out();
        $display("checks %0d errors %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    // ==========================================================
    // Scenarios
    task automatic t_reset();
        chk({6'h0, oe, pin}, 8'h01, "pin after reset");
        rchk(8'h08, 8'h80);
        rchk(8'h0f, 8'h01);
        rchk(8'h16, 8'h01);
        rchk(8'h10, 8'h01);
        rchk(8'h17, 8'h01);
        rchk(8'h11, 8'h01);
        rchk(8'h20, 8'h00);
    endtask
    task automatic t_fields();
        u_rtcam_host.wr(8'h10, 8'hff);
        rchk(8'h10, 8'h3f);
        u_rtcam_host.wr(8'h11, 8'hff);
        rchk(8'h11, 8'h1f);
        u_rtcam_host.wr(8'h16, 8'hff);
        rchk(8'h16, 8'h77);
    endtask
    task automatic try(input bit a1, input logic [2:0] m,
        input logic [7:0] r, v, ctl, input logic [6:0] hr, input bit f);
        logic [7:0] w;
        w = a1 ? 8'h16 : 8'h0f;
        @(negedge clk);
        now = '0;
        u_rtcam_host.arm(w, r, v, ctl, m);
        @(negedge clk);
        now = '{8'h42, 7'h25, 7'h13, hr, 3'h3, 6'h17, 5'h05};
        repeat (4) @(negedge clk);
        rchk(w, {1'b0, m, f, 3'h3});
        chk({6'h0, oe, pin}, {6'h0, f, ~f}, "alarm pin");
        u_rtcam_host.wr(8'h08, 8'h00);
        u_rtcam_host.wr(w, 8'h03);
    endtask
    task automatic t_codes();
        try(0, 3'h0, 8'h0c, 8'h25, 8'h10, 7'h09, 1);
        try(0, 3'h1, 8'h0d, 8'h13, 8'h10, 7'h09, 1);
        try(0, 3'h2, 8'h0e, 8'h09, 8'h10, 7'h09, 1);
        try(0, 3'h2, 8'h0e, 8'h29, 8'h10, 7'h69, 1);
        try(0, 3'h2, 8'h0e, 8'h09, 8'h10, 7'h69, 0);
        try(0, 3'h3, 8'h0f, 8'h33, 8'h10, 7'h09, 1);
        try(0, 3'h4, 8'h10, 8'h17, 8'h10, 7'h09, 1);
        try(0, 3'h5, 8'h0c, 8'h25, 8'h10, 7'h09, 0);
        try(0, 3'h6, 8'h0c, 8'h25, 8'h10, 7'h09, 0);
        try(0, 3'h7, 8'h11, 8'h06, 8'h10, 7'h09, 0);
        try(0, 3'h7, 8'h11, 8'h05, 8'h10, 7'h09, 1);
        try(1, 3'h5, 8'h12, 8'h42, 8'h20, 7'h09, 1);
        try(1, 3'h0, 8'h13, 8'h25, 8'h00, 7'h09, 0);
        try(1, 3'h4, 8'h17, 8'h17, 8'h20, 7'h09, 1);
        try(1, 3'h7, 8'h14, 8'h13, 8'h20, 7'h00, 1);
    endtask
    task automatic t_pair();
        @(negedge clk);
        now = '0;
        u_rtcam_host.arm(8'h0f, 8'h0c, 8'h25, 8'h10, 3'h0);
        u_rtcam_host.arm(8'h16, 8'h13, 8'h25, 8'h30, 3'h0);
        @(negedge clk);
        now.sec = 7'h25;
        repeat (4) @(negedge clk);
        u_rtcam_host.wr(8'h0f, 8'h03);
        repeat (3) @(negedge clk);
        chk({6'h0, oe, pin}, 8'h02, "pin held");
        rchk(8'h0f, 8'h03);
        u_rtcam_host.wr(8'h16, 8'h03);
        repeat (3) @(negedge clk);
        chk({6'h0, oe, pin}, 8'h01, "pin released");
        u_rtcam_host.wr(8'h08, 8'h00);
    endtask
    // A control value of zero keeps the settings already loaded.
    task automatic meas(input logic [7:0] ctl, input bit dr, input int e);
        int t;
        logic p;
        if (ctl !== 8'h00) u_rtcam_host.wr(8'h08, ctl);
        repeat (8) @(negedge clk);
        drop = dr;
        t = 0;
        p = pin;
        repeat (64) begin
            @(negedge clk);
            if (pin !== p) t++;
            p = pin;
        end
        drop = 1'b0;
        chk({7'h0, t > e - 2 && t < e + 2}, 8'h01, "square wave");
    endtask
    task automatic t_sqw();
        meas(8'h42, 1'b0, 32 / (DIV_8K / 2));
        meas(8'h41, 1'b0, 32 / (DIV_4K / 2));
        meas(8'h43, 1'b0, 64);
        meas(8'h43, 1'b1, 64);
        meas(8'h42, 1'b1, 0);
        meas(8'h40, 1'b0, 0);
        meas(8'h47, 1'b0, 0);
        chk({6'h0, crs, oe}, 8'h03, "coarse trim");
        meas(8'h0b, 1'b0, 0);
        chk({6'h0, ext, oe}, 8'h02, "external input");
    endtask
    task automatic t_backup();
        u_rtcam_host.wr(8'h08, 8'h42);
        @(negedge clk);
        bkp = 1'b1;
        now = '0;
        repeat (3) @(negedge clk);
        chk({7'h0, oe}, 8'h00, "no wave on backup");
        u_rtcam_host.arm(8'h0f, 8'h0c, 8'h25, 8'h52, 3'h0);
        @(negedge clk);
        now.sec = 7'h25;
        repeat (4) @(negedge clk);
        chk({6'h0, oe, pin}, 8'h02, "alarm on backup");
        u_rtcam_host.wr(8'h0f, 8'h03);
        @(negedge clk);
        bkp = 1'b0;
        rchk(8'h08, 8'hd2);
        meas(8'h00, 1'b0, 32 / (DIV_8K / 2));
    endtask
    initial begin
        repeat (5) @(negedge clk);
        rst_b = 1'b1;
        repeat (3) @(negedge clk);
        t_reset();
        t_fields();
        t_codes();
        t_pair();
        t_sqw();
        t_backup();
        close_out();
    end
    initial begin
        #100us;
        error_cnt++;
        close_out();
    end
endmodule
